// File: hdl/lcs_defines.svh
`ifndef LCS_DEFINES_SVH
`define LCS_DEFINES_SVH

// ----------------------------------------
// register offsets (printed offsets are register indexes)
// ----------------------------------------
`define LCS_IDX_LINK_CONTROL_SECOND      12'h070
`define LCS_IDX_LINK_STATUS_SECOND       12'h072
`define LCS_IDX_SLOT_CAPABILITIES_SECOND 12'h074
`define LCS_IDX_PORT_CONTROL             12'h080
`define LCS_IDX_PORT_STATUS              12'h081

// ----------------------------------------
// link control second field positions, plus status bit 0
// ----------------------------------------
`define LCS_TARGET_SPEED_LSB  0
`define LCS_TARGET_SPEED_MSB  3
`define LCS_ENTER_COMP_BIT    4
`define LCS_ASD_BIT           5
`define LCS_SDE_BIT           6
`define LCS_TM_LSB            7
`define LCS_TM_MSB            9
`define LCS_MOD_COMP_BIT      10
`define LCS_COMP_SKIP_BIT     11
`define LCS_COMP_DEEMPH_BIT   12
`define LCS_CUR_DEEMPH_BIT    0

// ----------------------------------------
// reset values and codes
// ----------------------------------------
`define LCS_TARGET_SPEED_RST  4'h2
`define LCS_SPEED_GEN1        4'h1
`define LCS_SPEED_GEN2        4'h2
`define LCS_TM_NORMAL         3'h0
`define LCS_TM_MAX_LEGAL      3'h5

`endif

// File: hdl/lcs_pkg.sv
package lcs_pkg;

  // ltssm substates this block reacts to
  typedef enum logic [2:0]
  {
    LCS_ST_OTHER      = 3'b000,
    LCS_ST_POLL_CONF  = 3'b001,
    LCS_ST_POLL_COMP  = 3'b010,
    LCS_ST_RCV_LOCK   = 3'b011,
    LCS_ST_RCV_SPEED  = 3'b100
  } lcs_ltssm_t;

  // compliance pattern selector driven to the phy
  typedef enum logic [1:0]
  {
    LCS_PAT_NONE      = 2'b00,
    LCS_PAT_NORMAL    = 2'b01,
    LCS_PAT_MODIFIED  = 2'b10
  } lcs_pattern_t;

endpackage

// File: hdl/lcs_sync.sv
`timescale 1ns/1ps

// two flip-flop synchroniser for levels from outside the clock domain
module lcs_sync
  import lcs_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // ----------------------------------------
  // sync stages
  // ----------------------------------------
  // first stage feeds only the second one
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q   <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// File: hdl/lcs_apply_reg.sv
`timescale 1ns/1ps

// shadow that takes a programmed value only on an apply strobe
module lcs_apply_reg
  import lcs_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             clear,
  input  wire logic             apply,
  input  wire logic [WIDTH-1:0] prog_val,
  output logic      [WIDTH-1:0] live_val
);

  // ----------------------------------------
  // shadow register
  // ----------------------------------------
  // clear takes priority, the line must be back in normal range
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      live_val <= '0;
    else if (clear)
      live_val <= '0;
    else if (apply)
      live_val <= prog_val;
  end

endmodule

// File: hdl/lcs_link_ctl2.sv
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "lcs_defines.svh"

// How it works
// - autonomous speed disable reads as zero
// - no autonomous speed changes besides reliability
// - software retrain speed changes ignore disable bit
// - downstream de-emphasis at 5 Gbps from bit
// - upstream bit only sets advertised preference
// - no de-emphasis effect at 2.5 Gbps/low-swing
// - de-emphasis change applied in Recovery.Speed
// - margin code selects launch level; 6-7 reserved
// - margin cleared on Polling.Configuration entry
// - normal margin uses serdes drive registers
// - new margin applied in Recovery.RcvrLock
// - modified compliance pattern when bit set
// - compliance skip sets inserted when bit set
// - compliance de-emphasis only after enter-compliance
// - status bit 0 shows current de-emphasis
// - target speed field stored as written, any 4-bit code
module lcs_link_ctl2
  import lcs_pkg::*;
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [13:0]  paddr,
  input  wire logic [31:0]  pwdata,
  input  wire logic [3:0]   pstrb,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire logic         hot_reset_n,
  input  wire logic         port_is_downstream,
  input  wire logic         link_at_gen2,
  input  wire logic         low_swing,
  input  wire logic [2:0]   ltssm_state,
  input  wire logic         partner_deemph,
  output logic              tx_deemph_35,
  output logic              adv_deemph_35,
  output logic              deemph_active,
  output logic [2:0]        tx_margin_live,
  output logic              use_serdes_drive,
  output logic [1:0]        comp_pattern,
  output logic              comp_skip_insert,
  output logic [3:0]        target_speed,
  output logic              enter_compliance,
  output logic              autonomous_speed_disable
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic [3:0]   target_speed_q;
  logic         enter_compliance_q;
  logic         sde_q;
  logic [2:0]   tm_q;
  logic         mod_comp_q;
  logic         comp_skip_q;
  logic         comp_deemph_q;
  logic         cur_deemph_q;
  logic         comp_by_enter_compliance_q;
  logic [31:0]  prdata_q;
  logic [15:0]  ctl_rd;
  logic [15:0]  sts_rd;
  logic [31:0]  rd_d;
  logic         err_d;
  logic         wr_en;
  logic         rd_en;
  logic [11:0]  reg_idx;
  logic         idx_hit;
  logic         lo_hit;
  logic         hi_hit;
  logic         sde_live;
  logic [2:0]   tm_live;
  logic [2:0]   ltssm_s;
  logic         hot_reset_s;
  logic         partner_deemph_s;
  logic         dn_s;
  logic         gen2_s;
  logic         low_swing_s;
  lcs_ltssm_t   ltssm;
  lcs_ltssm_t   ltssm_prev_q;
  logic [2:0]   ltssm_s_d1_q;
  logic         comp_from_enter_compliance;
  logic         enter_poll_conf;
  logic         enter_poll_comp;
  logic         pass_rcv_lock;
  logic         pass_rcv_speed;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // phy status pins come from the link clock area of the chip
  // each bit is synchronised alone; the ltssm code is filtered further below
  lcs_sync #(
    .WIDTH (8)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({ltssm_state, hot_reset_n, partner_deemph, port_is_downstream, link_at_gen2, low_swing}),
    .sync_out ({ltssm_s, hot_reset_s, partner_deemph_s, dn_s, gen2_s, low_swing_s})
  );

  // a code is taken only once two samples agree, so skewed bits never show a false substate
  assign ltssm = (ltssm_s == ltssm_s_d1_q) ? lcs_ltssm_t'(ltssm_s) : ltssm_prev_q;

  // ----------------------------------------
  // ltssm transition detection
  // ----------------------------------------
  // one register of the previous state turns levels into entry pulses
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ltssm_s_d1_q <= 3'h0;
      ltssm_prev_q <= LCS_ST_OTHER;
    end
    else
    begin
      ltssm_s_d1_q <= ltssm_s;
      ltssm_prev_q <= ltssm;
    end
  end

  assign enter_poll_conf = (ltssm == LCS_ST_POLL_CONF) && (ltssm_prev_q != LCS_ST_POLL_CONF);
  assign enter_poll_comp = (ltssm == LCS_ST_POLL_COMP) && (ltssm_prev_q != LCS_ST_POLL_COMP);
  assign pass_rcv_lock   = (ltssm == LCS_ST_RCV_LOCK)  && (ltssm_prev_q != LCS_ST_RCV_LOCK);
  assign pass_rcv_speed  = (ltssm == LCS_ST_RCV_SPEED) && (ltssm_prev_q != LCS_ST_RCV_SPEED);

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  // two 16-bit registers share word 0x070 (word 0x072 holds status alone), so decode by word then lane
  // lanes 2 and 3 of that word hold status, so their strobes are ignored
  assign reg_idx = 12'(paddr[13:2]);
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && penable && !pwrite;
  assign idx_hit = (reg_idx == `LCS_IDX_LINK_CONTROL_SECOND)
                || (reg_idx == `LCS_IDX_LINK_STATUS_SECOND)
                || (reg_idx == `LCS_IDX_SLOT_CAPABILITIES_SECOND)
                || (reg_idx == `LCS_IDX_PORT_CONTROL)
                || (reg_idx == `LCS_IDX_PORT_STATUS);
  assign lo_hit  = wr_en && (reg_idx == `LCS_IDX_LINK_CONTROL_SECOND) && pstrb[0];
  assign hi_hit  = wr_en && (reg_idx == `LCS_IDX_LINK_CONTROL_SECOND) && pstrb[1];

  // zero-wait slave
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign prdata  = prdata_q;

  // ----------------------------------------
  // sticky control fields
  // ----------------------------------------
  // sticky fields keep their value across hot reset; only presetn clears them
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      target_speed_q     <= `LCS_TARGET_SPEED_RST;
      enter_compliance_q <= 1'b0;
      mod_comp_q         <= 1'b0;
      comp_skip_q        <= 1'b0;
      comp_deemph_q      <= 1'b0;
    end
    else
    begin
      if (lo_hit)
      begin
        target_speed_q     <= pwdata[`LCS_TARGET_SPEED_MSB:`LCS_TARGET_SPEED_LSB];
        enter_compliance_q <= pwdata[`LCS_ENTER_COMP_BIT];
      end
      if (hi_hit)
      begin
        mod_comp_q    <= pwdata[`LCS_MOD_COMP_BIT];
        comp_skip_q   <= pwdata[`LCS_COMP_SKIP_BIT];
        comp_deemph_q <= pwdata[`LCS_COMP_DEEMPH_BIT];
      end
    end
  end

  // ----------------------------------------
  // transmit margin
  // ----------------------------------------
  // hardware clear on polling.configuration entry beats a software write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tm_q <= `LCS_TM_NORMAL;
    else if (enter_poll_conf)
      tm_q <= `LCS_TM_NORMAL;
    else if (lo_hit && pstrb[1])
      tm_q <= pwdata[`LCS_TM_MSB:`LCS_TM_LSB];
    else if (lo_hit)
      tm_q <= {tm_q[2:1], pwdata[`LCS_TM_LSB]};
    else if (hi_hit)
      tm_q <= {pwdata[`LCS_TM_MSB:`LCS_TM_LSB+1], tm_q[0]};
  end

  // ----------------------------------------
  // selectable de-emphasis
  // ----------------------------------------
  // not sticky, so a hot reset returns it to -6 dB
  // a hot reset and a write in one cycle leave it cleared
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sde_q <= 1'b0;
    else if (!hot_reset_s)
      sde_q <= 1'b0;
    else if (lo_hit)
      sde_q <= pwdata[`LCS_SDE_BIT];
  end

  // ----------------------------------------
  // line-side shadows
  // ----------------------------------------
  // the line only sees new de-emphasis and margin settings at the allowed ltssm points
  lcs_apply_reg #(
    .WIDTH (1)
  ) u_sde_apply (
    .pclk     (pclk),
    .presetn  (presetn),
    .clear    (1'b0),
    .apply    (pass_rcv_speed),
    .prog_val (sde_q),
    .live_val (sde_live)
  );

  lcs_apply_reg #(
    .WIDTH (3)
  ) u_tm_apply (
    .pclk     (pclk),
    .presetn  (presetn),
    .clear    (enter_poll_conf),
    .apply    (pass_rcv_lock),
    .prog_val (tm_q),
    .live_val (tm_live)
  );

  // reserved codes 6 and 7 fall back to normal range
  assign tx_margin_live   = (tm_live > `LCS_TM_MAX_LEGAL) ? `LCS_TM_NORMAL : tm_live;
  assign use_serdes_drive = (tx_margin_live == `LCS_TM_NORMAL);

  // ----------------------------------------
  // de-emphasis outputs
  // ----------------------------------------
  // at gen1 and low swing the line ignores the selection; only the advertised bit still follows it
  // upstream the line follows whatever the partner chose, except in compliance entered through enter-compliance
  assign deemph_active = gen2_s && !low_swing_s;
  assign adv_deemph_35 = sde_live;
  assign tx_deemph_35  = !deemph_active ? 1'b0 :
                         (ltssm == LCS_ST_POLL_COMP && comp_from_enter_compliance) ? comp_deemph_q :
                         dn_s ? sde_live : partner_deemph_s;

  // ----------------------------------------
  // compliance control
  // ----------------------------------------
  // remember whether the compliance entry came from enter-compliance
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      comp_by_enter_compliance_q <= 1'b0;
    else if (enter_poll_comp)
      comp_by_enter_compliance_q <= enter_compliance_q;
    else if (ltssm != LCS_ST_POLL_COMP)
      comp_by_enter_compliance_q <= 1'b0;
  end

  // the entry cycle itself already knows why compliance was entered
  assign comp_from_enter_compliance = enter_poll_comp ? enter_compliance_q : comp_by_enter_compliance_q;

  assign comp_pattern = (ltssm != LCS_ST_POLL_COMP) ? LCS_PAT_NONE :
                        mod_comp_q ? LCS_PAT_MODIFIED : LCS_PAT_NORMAL;
  assign comp_skip_insert = (ltssm == LCS_ST_POLL_COMP) && comp_skip_q;

  assign target_speed     = target_speed_q;
  assign enter_compliance = enter_compliance_q;
  // no autonomous speed logic exists, so the disable is tied off
  assign autonomous_speed_disable = 1'b0;

  // ----------------------------------------
  // current de-emphasis status
  // ----------------------------------------
  // held at -6 dB while at 2.5 Gbps, where the value has no meaning
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cur_deemph_q <= 1'b0;
    else
      cur_deemph_q <= gen2_s ? tx_deemph_35 : 1'b0;
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  // read view of every word; reserved bits are forced to zero
  // unmapped words read zero rather than raise an error, to keep software simple
  always_comb
  begin
    ctl_rd = 16'h0000;
    ctl_rd[`LCS_TARGET_SPEED_MSB:`LCS_TARGET_SPEED_LSB] = target_speed_q;
    ctl_rd[`LCS_ENTER_COMP_BIT]  = enter_compliance_q;
    ctl_rd[`LCS_ASD_BIT]         = 1'b0;
    ctl_rd[`LCS_SDE_BIT]         = sde_q;
    ctl_rd[`LCS_TM_MSB:`LCS_TM_LSB] = tm_q;
    ctl_rd[`LCS_MOD_COMP_BIT]    = mod_comp_q;
    ctl_rd[`LCS_COMP_SKIP_BIT]   = comp_skip_q;
    ctl_rd[`LCS_COMP_DEEMPH_BIT] = comp_deemph_q;
    sts_rd = 16'h0000;
    sts_rd[`LCS_CUR_DEEMPH_BIT]  = cur_deemph_q;
    rd_d  = 32'h0000_0000;
    err_d = 1'b0;
    unique case (reg_idx)
      `LCS_IDX_LINK_CONTROL_SECOND:      rd_d = {sts_rd, ctl_rd};
      `LCS_IDX_LINK_STATUS_SECOND:       rd_d = {16'h0000, sts_rd};
      `LCS_IDX_SLOT_CAPABILITIES_SECOND: rd_d = 32'h0000_0000;
      `LCS_IDX_PORT_CONTROL:             rd_d = {28'h0000000, low_swing_s, gen2_s, dn_s, hot_reset_s};
      `LCS_IDX_PORT_STATUS:              rd_d = {21'h000000, tx_margin_live, comp_pattern,
                                                 comp_skip_insert, tx_deemph_35, 1'b0, ltssm_s};
      default:                           err_d = !idx_hit;
    endcase
  end

  // ----------------------------------------
  // read data register
  // ----------------------------------------
  // captured in setup so data is stable through the single access cycle
  // live fields are a snapshot of the setup edge, not of the access edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata_q <= err_d ? 32'h0000_0000 : rd_d;
    else if (rd_en)
      prdata_q <= prdata_q;
  end

endmodule

// File: test/lcs_checker.sv
`timescale 1ns/1ps

// ----
// port checks
// ----
module lcs_checker
  import lcs_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        link_at_gen2,
  input wire logic        low_swing,
  input wire logic [2:0]  ltssm_state,
  input wire logic        deemph_active,
  input wire logic [2:0]  tx_margin_live,
  input wire logic        use_serdes_drive,
  input wire logic [1:0]  comp_pattern,
  input wire logic        autonomous_speed_disable
);
  // pins reach the logic through two flops, so causes are looked up 2 to 4 edges back
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  asd_zero_a : assert property (autonomous_speed_disable == 1'b0)
    else $error("speed disable bit not zero");
  margin_legal_a : assert property (tx_margin_live <= 3'h5)
    else $error("reserved margin code on line");
  serdes_sel_a : assert property (use_serdes_drive == (tx_margin_live == 3'h0))
    else $error("drive source does not follow margin");
  margin_apply_a : assert property ($changed(tx_margin_live) |->
    $past(ltssm_state, 2) inside {LCS_ST_RCV_LOCK, LCS_ST_POLL_CONF} ||
    $past(ltssm_state, 3) inside {LCS_ST_RCV_LOCK, LCS_ST_POLL_CONF} ||
    $past(ltssm_state, 4) inside {LCS_ST_RCV_LOCK, LCS_ST_POLL_CONF})
    else $error("margin changed outside lock or configuration");
  pattern_src_a : assert property (comp_pattern != LCS_PAT_NONE |->
    $past(ltssm_state, 2) == LCS_ST_POLL_COMP || $past(ltssm_state, 3) == LCS_ST_POLL_COMP)
    else $error("compliance pattern outside compliance");
  resv_zero_a : assert property (psel && !penable && !pwrite && paddr[13:2] == 12'h070 |=>
    prdata[31:17] == 15'h0 && prdata[15:13] == 3'h0 && !prdata[5])
    else $error("reserved control bits read non zero");
  caps_zero_a : assert property (psel && !penable && !pwrite && paddr[13:2] == 12'h074 |=>
    prdata == 32'h0)
    else $error("slot capabilities read non zero");
  deemph_gate_a : assert property (deemph_active |->
    ($past(link_at_gen2, 2) || $past(link_at_gen2, 3)) && !($past(low_swing, 2) && $past(low_swing, 3)))
    else $error("de-emphasis active at low rate or low swing");
endmodule

bind lcs_link_ctl2 lcs_checker chk_u
(
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .link_at_gen2, .low_swing,
  .ltssm_state, .deemph_active, .tx_margin_live, .use_serdes_drive, .comp_pattern, .autonomous_speed_disable
);

// File: test/lcs_partner.sv
`timescale 1ns/1ps

// ----
// link partner: walks the substates it is asked for, promptly or slowly
// ----
module lcs_partner
  import lcs_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [2:0] want,
  input  wire logic       slow,
  input  wire logic       gen2_req,
  input  wire logic       pref_35,
  output logic      [2:0] ltssm_state,
  output logic            link_at_gen2,
  output logic            partner_deemph
);
  logic [3:0] lag_q;

  // hold each substate for a lag before moving on
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lag_q <= 4'h0;
    else if (ltssm_state == want)
      lag_q <= slow ? 4'h8 : 4'h3;
    else if (lag_q != 4'h0)
      lag_q <= lag_q - 4'h1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ltssm_state <= 3'h0;
    else if (ltssm_state != want && lag_q == 4'h0)
      ltssm_state <= want;
  end

  // rate and our own de-emphasis move only in the speed substate
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      link_at_gen2   <= 1'b0;
      partner_deemph <= 1'b0;
    end
    else if (ltssm_state == LCS_ST_RCV_SPEED)
    begin
      link_at_gen2   <= gen2_req;
      partner_deemph <= pref_35;
    end
  end
endmodule

// File: test/tb_top.sv
`timescale 1ns/1ps

// ----
// bench signals and design
// ----
module tb_top
  import lcs_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, hot_reset_n, port_is_downstream, low_swing;
  logic        slow, gen2_req, pref_35, link_at_gen2, partner_deemph, pready, pslverr, tx_deemph_35;
  logic        adv_deemph_35, deemph_active, use_serdes_drive, comp_skip_insert, enter_compliance;
  logic        autonomous_speed_disable;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb, target_speed;
  logic [2:0]  want, ltssm_state, tx_margin_live;
  logic [1:0]  comp_pattern;
  int          n_fail, n_compared;

  lcs_link_ctl2 dut_u
  (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .hot_reset_n, .port_is_downstream, .link_at_gen2, .low_swing, .ltssm_state, .partner_deemph,
    .tx_deemph_35, .adv_deemph_35, .deemph_active, .tx_margin_live, .use_serdes_drive, .comp_pattern,
    .comp_skip_insert, .target_speed, .enter_compliance, .autonomous_speed_disable
  );

  lcs_partner partner_u
  (
    .pclk, .presetn, .want, .slow, .gen2_req, .pref_35, .ltssm_state, .link_at_gen2, .partner_deemph
  );

  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // ----
  // helpers
  // ----
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic final_report();
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // one transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk) penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 40);
    if (pready !== 1'b1)
    begin
      chk("apb_wait", 32'h1, 32'h0);
      final_report();
    end
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wreg(input logic [11:0] idx, input logic [31:0] wd);
    logic [31:0] rd;
    apb(1'b1, idx, wd, rd);
  endtask

  task automatic rchk(input string nm, input logic [11:0] idx, input logic [31:0] exp);
    logic [31:0] rd;
    apb(1'b0, idx, 32'h0, rd);
    chk(nm, rd, exp);
  endtask

  // outputs are looked at on the falling edge, clear of the launching edge
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask

  // ask the partner for a substate, then give the synchronisers time
  task automatic go(input logic [2:0] st);
    int n;
    @(posedge pclk) want <= st;
    n = 0;
    while (ltssm_state !== st && n < 40)
    begin
      @(posedge pclk);
      n++;
    end
    if (ltssm_state !== st)
    begin
      chk("ltssm_wait", 32'h1, 32'h0);
      final_report();
    end
    settle(5);
  endtask

  // ----
  // scenarios
  // ----
  task automatic t_reset();
    rchk("ctl_rst", 12'h070, 32'h0000_0002);
    rchk("sts_rst", 12'h072, 32'h0000_0000);
    rchk("cap_rst", 12'h074, 32'h0000_0000);
    chk("asd_pin", {31'h0, autonomous_speed_disable}, 32'h0);
  endtask

  // all ones except target speed code 1 and margin code 5
  task automatic t_write();
    wreg(12'h070, 32'hFFFF_FEF1);
    rchk("ctl_mask", 12'h070, 32'h0000_1ED1);
    wreg(12'h074, 32'hFFFF_FFFF);
    rchk("cap_ro", 12'h074, 32'h0000_0000);
    settle(1);
    chk("tgt_speed", {28'h0, target_speed}, 32'h1);
    chk("enter_compliance_pin", {31'h0, enter_compliance}, 32'h1);
    chk("no_slverr", {31'h0, pslverr}, 32'h0);
  endtask

  task automatic t_margin();
    chk("tm_held", {29'h0, tx_margin_live}, 32'h0);
    chk("drv_serdes", {31'h0, use_serdes_drive}, 32'h1);
    go(LCS_ST_RCV_LOCK);
    chk("tm_live", {29'h0, tx_margin_live}, 32'h5);
    chk("drv_margin", {31'h0, use_serdes_drive}, 32'h0);
    go(LCS_ST_POLL_CONF);
    rchk("tm_clear", 12'h070, 32'h0000_1C51);
  endtask

  task automatic t_comp();
    go(LCS_ST_POLL_COMP);
    chk("pat_mod", {30'h0, comp_pattern}, 32'(LCS_PAT_MODIFIED));
    chk("skip_on", {31'h0, comp_skip_insert}, 32'h1);
    wreg(12'h070, 32'h0000_1851);
    settle(1);
    chk("pat_norm", {30'h0, comp_pattern}, 32'(LCS_PAT_NORMAL));
    go(LCS_ST_OTHER);
    chk("pat_none", {30'h0, comp_pattern}, 32'(LCS_PAT_NONE));
  endtask

  // downstream at 5 Gbps: selection waits for the speed substate
  task automatic t_down();
    chk("sde_wait", {31'h0, tx_deemph_35}, 32'h0);
    chk("adv_wait", {31'h0, adv_deemph_35}, 32'h0);
    go(LCS_ST_RCV_SPEED);
    go(LCS_ST_OTHER);
    chk("sde_on", {31'h0, tx_deemph_35}, 32'h1);
    rchk("cur_de", 12'h070, 32'h0001_1851);
    @(posedge pclk) low_swing <= 1'b1;
    settle(5);
    chk("low_swing", {31'h0, deemph_active}, 32'h0);
    @(posedge pclk) low_swing <= 1'b0;
  endtask

  // upstream with a slow partner that picks 6 dB
  task automatic t_up();
    @(posedge pclk)
    begin
      port_is_downstream <= 1'b0;
      slow               <= 1'b1;
    end
    go(LCS_ST_RCV_SPEED);
    go(LCS_ST_OTHER);
    chk("adv_pref", {31'h0, adv_deemph_35}, 32'h1);
    chk("tx_partner", {31'h0, tx_deemph_35}, 32'h0);
    go(LCS_ST_POLL_COMP);
    chk("comp_de", {31'h0, tx_deemph_35}, 32'h1);
    go(LCS_ST_OTHER);
  endtask

  task automatic t_hot();
    @(posedge pclk) hot_reset_n <= 1'b0;
    settle(4);
    @(posedge pclk) hot_reset_n <= 1'b1;
    settle(4);
    rchk("sticky", 12'h070, 32'h0000_1811);
  endtask

  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 14'h0;
    pwdata = 32'h0;
    pstrb = 4'hF;
    want = LCS_ST_OTHER;
    {slow, low_swing, pref_35} = 3'h0;
    {hot_reset_n, port_is_downstream, gen2_req} = 3'h7;
    n_fail = 0;
    n_compared = 0;
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_write();
    t_margin();
    t_comp();
    t_down();
    t_up();
    t_hot();
    final_report();
  end
endmodule
